// *** rtl/throttle_channel.sv ***
// Purpose: throttle channel mode machine and position calibration sequencer
// Assumes: all inputs synchronous to clk_sys; voltages in signed millivolts
// Notes:   lead/lag and full PID are replaced by a proportional term
`timescale 1ns/1ns

module throttle_channel #(
  parameter int TICK_CYCLES = throttle_pkg::TICK_CYCLES_DEF
) (
  // clock, reset, enable
  input  wire logic                                  clk_sys,
  input  wire logic                                  rst_n,
  input  wire logic                                  clk_en,
  // mode
  input  wire logic [1:0]                            requested_op_state,
  output logic [1:0]                                 current_op_state,
  // sensor selection and capture
  input  wire logic                                  sensor_swap_select,
  input  wire logic                                  capture_strobe,
  input  wire logic signed [throttle_pkg::VOLT_W-1:0] cal_in_range_min,
  input  wire logic signed [throttle_pkg::VOLT_W-1:0] cal_in_range_max,
  // control inputs
  input  wire logic [15:0]                           pwm_switch_rate,
  input  wire logic [throttle_pkg::POS_W-1:0]        target_position,
  // sensors
  input  wire logic signed [throttle_pkg::VOLT_W-1:0] sense_input_a,
  input  wire logic signed [throttle_pkg::VOLT_W-1:0] sense_input_b,
  // calibration settings
  input  wire logic [throttle_pkg::DELAY_W-1:0]      start_settle_delay,
  input  wire logic [throttle_pkg::DELAY_W-1:0]      post_up_settle_delay,
  input  wire logic [throttle_pkg::DELAY_W-1:0]      post_down_settle_delay,
  input  wire logic signed [throttle_pkg::VOLT_W-1:0] up_drive_initial,
  input  wire logic signed [throttle_pkg::VOLT_W-1:0] down_drive_initial,
  input  wire logic signed [throttle_pkg::VOLT_W-1:0] up_drive_step,
  input  wire logic signed [throttle_pkg::VOLT_W-1:0] down_drive_step,
  input  wire logic signed [throttle_pkg::VOLT_W-1:0] up_drive_limit,
  input  wire logic signed [throttle_pkg::VOLT_W-1:0] down_drive_limit,
  input  wire logic signed [throttle_pkg::VOLT_W-1:0] travel_min_change,
  // motor drive
  output logic signed [throttle_pkg::VOLT_W-1:0]     motor_drive,
  output logic [15:0]                                drive_pwm_rate,
  // position and calibration results
  output logic [throttle_pkg::POS_W-1:0]             primary_position,
  output logic signed [throttle_pkg::VOLT_W-1:0]     captured_position,
  output logic signed [throttle_pkg::VOLT_W-1:0]     range_min_out,
  output logic signed [throttle_pkg::VOLT_W-1:0]     range_max_out,
  output logic                                       pos_cal_complete
);

  localparam int VW = throttle_pkg::VOLT_W;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0001,
    ST_POS_CAL  = 4'b0010,
    ST_CTRL_CAL = 4'b0100,
    ST_CONTROL  = 4'b1000
  } op_state_e;

  typedef enum logic [5:0] {
    CAL_OFF         = 6'b000001,
    CAL_START_WAIT  = 6'b000010,
    CAL_UP          = 6'b000100,
    CAL_UP_SETTLE   = 6'b001000,
    CAL_DOWN        = 6'b010000,
    CAL_DOWN_SETTLE = 6'b100000
  } cal_state_e;

  op_state_e                op_q;
  cal_state_e               cal_q;
  logic [1:0]               req_prev_q;
  logic                     swap_q;
  logic signed [VW-1:0]     range_min_q;
  logic signed [VW-1:0]     range_max_q;
  logic signed [VW-1:0]     captured_q;
  logic signed [VW-1:0]     cal_drive_q;
  logic signed [VW-1:0]     step_sum_q;
  logic signed [VW-1:0]     last_v_q;
  logic signed [VW-1:0]     up_end_v_q;
  logic signed [VW-1:0]     motor_drive_q;
  logic [15:0]              pwm_rate_q;
  logic [throttle_pkg::POS_W-1:0] position_q;
  logic                     complete_q;
  logic                     pass_done;
  logic                     tmr_load;
  logic [throttle_pkg::DELAY_W-1:0] tmr_ms;
  logic                     tick;
  logic                     tmr_expired;
  logic signed [VW-1:0]     prim_v;
  logic signed [VW:0]       moved;
  logic signed [VW:0]       next_sum;
  logic signed [VW:0]       span;
  logic signed [VW:0]       off;
  logic [VW-1:0]            span_abs;
  logic [VW-1:0]            off_clamp;
  logic [throttle_pkg::NUM_W-1:0] numer;
  logic                     div_busy;
  logic                     div_done;
  logic [throttle_pkg::NUM_W-1:0] quot;
  logic signed [VW+1:0]     pos_err;
  logic signed [VW+1:0]     ctrl_drive;

  // ==========================================================================
  // primary sensor selection
  assign prim_v = swap_q ? sense_input_b : sense_input_a;

  // swap select and calibration inputs taken only on capture, never in control
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      swap_q     <= 1'b0;
      captured_q <= throttle_pkg::DRIVE_OFF;
    end else if (clk_en && capture_strobe && op_q != ST_CONTROL) begin
      swap_q     <= sensor_swap_select;
      captured_q <= prim_v;
    end
  end

  // active calibration output: from capture, or learned at end of a pass
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      range_min_q <= throttle_pkg::RANGE_MIN_RST;
      range_max_q <= throttle_pkg::RANGE_MAX_RST;
    end else if (clk_en) begin
      if (capture_strobe && op_q != ST_CONTROL) begin
        range_min_q <= cal_in_range_min;
        range_max_q <= cal_in_range_max;
      end else if (pass_done) begin
        range_min_q <= prim_v;
        range_max_q <= up_end_v_q;
      end
    end
  end

  // ==========================================================================
  // operating mode machine
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      op_q       <= ST_IDLE;
      req_prev_q <= throttle_pkg::MODE_IDLE;
    end else if (clk_en) begin
      req_prev_q <= requested_op_state;
      unique case (op_q)
        ST_IDLE: begin
          if (requested_op_state == throttle_pkg::MODE_POS_CAL) begin
            op_q <= ST_POS_CAL;
          end else if (requested_op_state == throttle_pkg::MODE_CONTROL) begin
            op_q <= ST_CONTROL;
          end else if (requested_op_state == throttle_pkg::MODE_CTRL_CAL &&
                       req_prev_q != throttle_pkg::MODE_CTRL_CAL) begin
            op_q <= ST_CTRL_CAL;
          end
        end
        ST_POS_CAL: begin
          if (requested_op_state == throttle_pkg::MODE_IDLE) begin
            op_q <= ST_IDLE;
          end else if (pass_done && requested_op_state == throttle_pkg::MODE_CONTROL) begin
            op_q <= ST_CONTROL;
          end else if (pass_done && requested_op_state != throttle_pkg::MODE_POS_CAL) begin
            op_q <= ST_IDLE;
          end
        end
        ST_CTRL_CAL: begin
          op_q <= ST_IDLE;
        end
        ST_CONTROL: begin
          if (requested_op_state == throttle_pkg::MODE_IDLE) begin
            op_q <= ST_IDLE;
          end
        end
        default: begin
          op_q <= ST_IDLE;
        end
      endcase
    end
  end

  // reported mode code
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      current_op_state <= throttle_pkg::MODE_IDLE;
    end else if (clk_en) begin
      unique case (op_q)
        ST_POS_CAL:  current_op_state <= throttle_pkg::MODE_POS_CAL;
        ST_CTRL_CAL: current_op_state <= throttle_pkg::MODE_CTRL_CAL;
        ST_CONTROL:  current_op_state <= throttle_pkg::MODE_CONTROL;
        default:     current_op_state <= throttle_pkg::MODE_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // settle timer on a millisecond tick
  settle_timer #(
    .TICK_CYCLES (TICK_CYCLES),
    .DELAY_W     (throttle_pkg::DELAY_W)
  ) u_timer (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .load    (tmr_load),
    .load_ms (tmr_ms),
    .tick    (tick),
    .expired (tmr_expired)
  );

  // step arithmetic and movement since the last tick
  always_comb begin
    tmr_load = 1'b0;
    tmr_ms   = start_settle_delay;
    if (cal_q == CAL_UP) begin
      moved    = {prim_v[VW-1], prim_v} - {last_v_q[VW-1], last_v_q};
      next_sum = {step_sum_q[VW-1], step_sum_q} + {up_drive_step[VW-1], up_drive_step};
    end else begin
      moved    = {last_v_q[VW-1], last_v_q} - {prim_v[VW-1], prim_v};
      next_sum = {step_sum_q[VW-1], step_sum_q} + {down_drive_step[VW-1], down_drive_step};
    end
    if (cal_q == CAL_OFF && op_q == ST_POS_CAL) begin
      tmr_load = 1'b1;
    end
    if (cal_q == CAL_UP && tick && moved < {travel_min_change[VW-1], travel_min_change} &&
        next_sum >= {up_drive_limit[VW-1], up_drive_limit}) begin
      tmr_load = 1'b1;
      tmr_ms   = post_up_settle_delay;
    end
    if (cal_q == CAL_DOWN && tick && moved < {travel_min_change[VW-1], travel_min_change} &&
        next_sum <= {down_drive_limit[VW-1], down_drive_limit}) begin
      tmr_load = 1'b1;
      tmr_ms   = post_down_settle_delay;
    end
  end

  assign pass_done = (cal_q == CAL_DOWN_SETTLE) && tmr_expired && op_q == ST_POS_CAL;

  // ==========================================================================
  // calibration sequencer, runs only while the mode is position calibration
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cal_q       <= CAL_OFF;
      cal_drive_q <= throttle_pkg::DRIVE_OFF;
      step_sum_q  <= throttle_pkg::DRIVE_OFF;
      last_v_q    <= throttle_pkg::DRIVE_OFF;
      up_end_v_q  <= throttle_pkg::RANGE_MAX_RST;
    end else if (clk_en) begin
      if (op_q != ST_POS_CAL) begin
        cal_q       <= CAL_OFF;
        cal_drive_q <= throttle_pkg::DRIVE_OFF;
      end else begin
        unique case (cal_q)
          CAL_OFF: begin
            cal_q <= CAL_START_WAIT;
          end
          CAL_START_WAIT: begin
            if (tmr_expired) begin
              cal_q       <= CAL_UP;
              cal_drive_q <= up_drive_initial;
              step_sum_q  <= throttle_pkg::DRIVE_OFF;
              last_v_q    <= prim_v;
            end
          end
          CAL_UP: begin
            if (tick) begin
              last_v_q <= prim_v;
              if (moved < {travel_min_change[VW-1], travel_min_change}) begin
                if (next_sum >= {up_drive_limit[VW-1], up_drive_limit}) begin
                  cal_q       <= CAL_UP_SETTLE;
                  cal_drive_q <= throttle_pkg::DRIVE_OFF;
                  up_end_v_q  <= prim_v;
                end else begin
                  cal_drive_q <= cal_drive_q + up_drive_step;
                  step_sum_q  <= next_sum[VW-1:0];
                end
              end
            end
          end
          CAL_UP_SETTLE: begin
            if (tmr_expired) begin
              cal_q       <= CAL_DOWN;
              cal_drive_q <= down_drive_initial;
              step_sum_q  <= throttle_pkg::DRIVE_OFF;
              last_v_q    <= prim_v;
            end
          end
          CAL_DOWN: begin
            if (tick) begin
              last_v_q <= prim_v;
              if (moved < {travel_min_change[VW-1], travel_min_change}) begin
                if (next_sum <= {down_drive_limit[VW-1], down_drive_limit}) begin
                  cal_q       <= CAL_DOWN_SETTLE;
                  cal_drive_q <= throttle_pkg::DRIVE_OFF;
                end else begin
                  cal_drive_q <= cal_drive_q + down_drive_step;
                  step_sum_q  <= next_sum[VW-1:0];
                end
              end
            end
          end
          CAL_DOWN_SETTLE: begin
            if (tmr_expired) begin
              cal_q       <= CAL_UP;
              cal_drive_q <= up_drive_initial;
              step_sum_q  <= throttle_pkg::DRIVE_OFF;
              last_v_q    <= prim_v;
            end
          end
          default: begin
            cal_q <= CAL_OFF;
          end
        endcase
      end
    end
  end

  // completion flag held until a new position calibration reaches its start settle wait
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      complete_q <= 1'b0;
    end else if (clk_en) begin
      if (pass_done) begin
        complete_q <= 1'b1;
      end else if (op_q == ST_POS_CAL && cal_q == CAL_START_WAIT) begin
        complete_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // primary position from the active calibration output
  always_comb begin
    span = {range_max_q[VW-1], range_max_q} - {range_min_q[VW-1], range_min_q};
    off  = {prim_v[VW-1], prim_v} - {range_min_q[VW-1], range_min_q};
    if (span < 0) begin
      span = -span;
      off  = -off;
    end
    span_abs = span[VW-1:0];
    if (off < 0) begin
      off_clamp = '0;
    end else if (off[VW-1:0] > span_abs) begin
      off_clamp = span_abs;
    end else begin
      off_clamp = off[VW-1:0];
    end
    numer = 32'(off_clamp) * 32'(throttle_pkg::FULL_TRAVEL);
  end

  pos_divider #(
    .NUM_W (throttle_pkg::NUM_W),
    .DEN_W (VW)
  ) u_div (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .start   (!div_busy),
    .numer   (numer),
    .denom   (span_abs),
    .busy    (div_busy),
    .done    (div_done),
    .quot    (quot)
  );

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      position_q <= '0;
    end else if (clk_en && div_done) begin
      position_q <= quot[throttle_pkg::POS_W-1:0];
    end
  end

  // ==========================================================================
  // proportional regulation toward the percent setpoint
  assign pos_err    = $signed({2'b00, target_position}) - $signed({2'b00, position_q});
  assign ctrl_drive = pos_err >>> throttle_pkg::CTRL_GAIN_SHIFT;

  // motor drive selected by mode
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      motor_drive_q <= throttle_pkg::DRIVE_OFF;
      pwm_rate_q    <= 16'h0000;
    end else if (clk_en) begin
      pwm_rate_q <= pwm_switch_rate;
      unique case (op_q)
        ST_POS_CAL: motor_drive_q <= cal_drive_q;
        ST_CONTROL: motor_drive_q <= ctrl_drive[VW-1:0];
        default:    motor_drive_q <= throttle_pkg::DRIVE_OFF;
      endcase
    end
  end

  // ==========================================================================
  // outputs
  assign motor_drive       = motor_drive_q;
  assign drive_pwm_rate    = pwm_rate_q;
  assign primary_position  = position_q;
  assign captured_position = captured_q;
  assign range_min_out     = range_min_q;
  assign range_max_out     = range_max_q;
  assign pos_cal_complete  = complete_q;

endmodule

// *** pkg/throttle_pkg.sv ***
// Purpose: shared constants for the throttle mode and position calibration block
// Assumes: voltages in signed millivolts, positions in hundredths of a percent
// Notes:   settle delays arrive in milliseconds, counted on a 1 ms prescaler tick

package throttle_pkg;

  // ==========================================================================
  // widths
  localparam int VOLT_W  = 16;
  localparam int DELAY_W = 16;
  localparam int POS_W   = 16;
  localparam int NUM_W   = 32;

  // ==========================================================================
  // operating mode codes on requested_op_state and current_op_state
  localparam logic [1:0] MODE_IDLE     = 2'h0;
  localparam logic [1:0] MODE_POS_CAL  = 2'h1;
  localparam logic [1:0] MODE_CTRL_CAL = 2'h2;
  localparam logic [1:0] MODE_CONTROL  = 2'h3;

  // ==========================================================================
  // timing: one settle tick per millisecond
  localparam int CLK_PERIOD_NS   = 10;
  localparam int TICK_TIME_NS    = 1000000;
  localparam int TICK_CYCLES_DEF = TICK_TIME_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // values
  localparam logic signed [VOLT_W-1:0] DRIVE_OFF     = 16'sh0000;  // 0 V
  localparam logic signed [VOLT_W-1:0] RANGE_MIN_RST = 16'sh0000;  // 0 V
  localparam logic signed [VOLT_W-1:0] RANGE_MAX_RST = 16'sh1388;  // 5 V
  localparam logic [POS_W-1:0]         FULL_TRAVEL   = 16'h2710;   // 100.00 %
  localparam int                       CTRL_GAIN_SHIFT = 2;

endpackage

// *** rtl/settle_timer.sv ***
// Purpose: millisecond prescaler and settle countdown
// Assumes: load has priority over counting
// Notes:   expired is high whenever no time remains and no load is applied
`timescale 1ns/1ns

module settle_timer #(
  parameter int TICK_CYCLES = throttle_pkg::TICK_CYCLES_DEF,
  parameter int DELAY_W     = throttle_pkg::DELAY_W
) (
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  input  wire logic               clk_en,
  // control
  input  wire logic               load,
  input  wire logic [DELAY_W-1:0] load_ms,
  // status
  output logic                    tick,
  output logic                    expired
);

  logic [31:0]        pre_q;
  logic [DELAY_W-1:0] remain_q;

  // ==========================================================================
  // prescaler: one tick pulse per millisecond
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pre_q <= 32'h0;
      tick  <= 1'b0;
    end else if (clk_en) begin
      tick  <= (pre_q == 32'(TICK_CYCLES - 1));
      pre_q <= (pre_q == 32'(TICK_CYCLES - 1)) ? 32'h0 : pre_q + 32'h1;
    end
  end

  // countdown of whole milliseconds
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      remain_q <= '0;
    end else if (clk_en) begin
      if (load) begin
        remain_q <= load_ms;
      end else if (tick && remain_q != '0) begin
        remain_q <= remain_q - 1'b1;
      end
    end
  end

  assign expired = (remain_q == '0) && !load;

endmodule

// *** rtl/pos_divider.sv ***
// Purpose: restoring divider turning sensor offset into travel fraction
// Assumes: start is ignored while busy
// Notes:   zero divisor gives a zero quotient
`timescale 1ns/1ns

module pos_divider #(
  parameter int NUM_W = throttle_pkg::NUM_W,
  parameter int DEN_W = throttle_pkg::VOLT_W
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  // operands
  input  wire logic             start,
  input  wire logic [NUM_W-1:0] numer,
  input  wire logic [DEN_W-1:0] denom,
  // result
  output logic                  busy,
  output logic                  done,
  output logic [NUM_W-1:0]      quot
);

  logic [NUM_W-1:0] rem_q;
  logic [DEN_W-1:0] den_q;
  logic [5:0]       cnt_q;
  logic [NUM_W:0]   trial;

  // one quotient bit per cycle
  assign trial = {rem_q, quot[NUM_W-1]} - {{(NUM_W+1-DEN_W){1'b0}}, den_q};

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rem_q <= '0;
      den_q <= '0;
      cnt_q <= 6'h00;
      quot  <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (!busy && start) begin
        rem_q <= '0;
        den_q <= denom;
        quot  <= numer;
        cnt_q <= 6'(NUM_W);
        busy  <= (denom != '0);
        done  <= (denom == '0);
        if (denom == '0) begin
          quot <= '0;
        end
      end else if (busy) begin
        if (!trial[NUM_W]) begin
          rem_q <= trial[NUM_W-1:0];
          quot  <= {quot[NUM_W-2:0], 1'b1};
        end else begin
          rem_q <= {rem_q[NUM_W-2:0], quot[NUM_W-1]};
          quot  <= {quot[NUM_W-2:0], 1'b0};
        end
        cnt_q <= cnt_q - 6'h01;
        if (cnt_q == 6'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule

// *** verif/throttle_channel_chk.sv ***
// Purpose: mode machine and drive checks
// Assumes: clk_en held high by the bench
// Notes:   sees top ports only
`timescale 1ns/1ns
module throttle_channel_chk #(
  parameter int TICK_CYCLES = 4
) (
  // clock and reset
  input wire logic               clk_sys,
  input wire logic               rst_n,
  // mode and drive
  input wire logic [1:0]         requested_op_state,
  input wire logic [1:0]         current_op_state,
  input wire logic signed [15:0] motor_drive,
  // calibration limits
  input wire logic signed [15:0] up_drive_initial,
  input wire logic signed [15:0] up_drive_limit,
  input wire logic signed [15:0] down_drive_initial,
  input wire logic signed [15:0] down_drive_limit
);
  // ==========================================================================
  // assertions
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_idle_no_drive: assert property (current_op_state == 2'h0 |-> motor_drive == 16'sh0000)
    else $error("drive seen in idle");
  a_cal_from_idle: assert property ($changed(current_op_state) && current_op_state == 2'h1 |->
    $past(current_op_state) == 2'h0) else $error("calibration entered from busy state");
  a_abort_at_once: assert property (current_op_state == 2'h1 && requested_op_state == 2'h0 |->
    ##2 current_op_state == 2'h0) else $error("idle request not taken at once");
  a_ctrl_cal_exit: assert property (current_op_state == 2'h2 |=> current_op_state == 2'h0)
    else $error("control calibration did not return to idle");
  a_control_holds: assert property (current_op_state == 2'h3 && $past(requested_op_state) != 2'h0 |=>
    current_op_state == 2'h3) else $error("control left without idle request");
  a_no_ctrl_to_cal: assert property (current_op_state == 2'h3 |=> current_op_state inside {2'h0, 2'h3})
    else $error("control went straight to calibration");
  a_control_entry: assert property ($changed(current_op_state) && current_op_state == 2'h3 |->
    $past(current_op_state) inside {2'h0, 2'h1}) else $error("control entered from bad state");
  a_cal_drive_range: assert property (current_op_state == 2'h1 |-> motor_drive <= up_drive_initial +
    up_drive_limit && motor_drive >= down_drive_initial + down_drive_limit) else $error("cal drive past limit");
endmodule

// *** verif/throttle_plant.sv ***
// Purpose: throttle plate with two position sensors
// Assumes: drive and sensors in millivolts
// Notes:   spring pulls an undriven plate back to rest
`timescale 1ns/1ns
module throttle_plant (
  // clock
  input wire logic               clk_sys,
  // motor side
  input wire logic signed [15:0] motor_drive,
  // sensor side
  output logic signed [15:0]     sense_input_a,
  output logic signed [15:0]     sense_input_b
);
  int d;
  int q;
  int p = 2500;
  // unknown drive reads as zero; next plate place
  always_comb d = motor_drive;
  always_comb q = (d == 0) ? p + (2500 - p) / 8 : p + d / 16;
  // plate is held by end stops at 500 and 4500
  always_ff @(posedge clk_sys) p <= (q > 4500) ? 4500 : ((q < 500) ? 500 : q);
  // second sensor falls as the plate opens
  assign sense_input_a = 16'(p);
  assign sense_input_b = 16'(4000 - p);
endmodule

// *** verif/throttle_channel_tb_top.sv ***
// Purpose: bench for the throttle channel
// Assumes: clk_en tied high, short settle tick
// Notes:   plate model answers the motor drive
`timescale 1ns/1ns
module throttle_channel_tb_top;
  logic               clk_sys, rst_n, capture_strobe, sensor_swap_select, pos_cal_complete;
  logic [1:0]         requested_op_state, current_op_state;
  logic [15:0]        pwm_switch_rate, drive_pwm_rate, target_position, primary_position;
  logic [15:0]        start_settle_delay, post_up_settle_delay, post_down_settle_delay;
  logic signed [15:0] cal_in_range_min, cal_in_range_max, sense_input_a, sense_input_b, motor_drive;
  logic signed [15:0] up_drive_initial, up_drive_step, up_drive_limit, travel_min_change;
  logic signed [15:0] down_drive_initial, down_drive_step, down_drive_limit;
  logic signed [15:0] captured_position, range_min_out, range_max_out;
  int                 err_count, num_checks;
  // ==========================================================================
  // design and plate
  throttle_channel #(.TICK_CYCLES(4)) DUT (.clk_sys, .rst_n, .clk_en(1'h1), .requested_op_state,
    .current_op_state, .sensor_swap_select, .capture_strobe, .cal_in_range_min, .cal_in_range_max,
    .pwm_switch_rate, .target_position, .sense_input_a, .sense_input_b, .start_settle_delay,
    .post_up_settle_delay, .post_down_settle_delay, .up_drive_initial, .down_drive_initial, .up_drive_step,
    .down_drive_step, .up_drive_limit, .down_drive_limit, .travel_min_change, .motor_drive, .drive_pwm_rate,
    .primary_position, .captured_position, .range_min_out, .range_max_out, .pos_cal_complete);
  throttle_plant plant (.clk_sys, .motor_drive, .sense_input_a, .sense_input_b);
  // ==========================================================================
  // shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t %s", $time, m);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic req(input logic [1:0] s);
    @(posedge clk_sys);
    requested_op_state <= s;
  endtask
  // bounded wait for a state, plus complete (k=1) or up drive (k=2)
  task automatic wait_for(input int k, input logic [1:0] s);
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk_sys);
      #1;
      if (current_op_state === s && (k == 0 || (k == 1 && pos_cal_complete === 1'h1) ||
          (k == 2 && motor_drive === up_drive_initial))) return;
    end
    err_count++;
    $display("BAD t=%0t wait ran out", $time);
    summarize();
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_swap;
    for (int i = 1; i >= 0; i--) begin
      @(posedge clk_sys);
      sensor_swap_select <= i[0];
      repeat (2) @(posedge clk_sys);
      #1 chk(captured_position, i ? 16'h0000 : 16'h09c4, "swap took effect early");
      @(posedge clk_sys);
      capture_strobe <= 1'h1;
      @(posedge clk_sys);
      capture_strobe <= 1'h0;
      #1 chk(captured_position, i ? 16'h09c4 : 16'h05dc, "captured wrong sensor");
    end
    repeat (80) @(posedge clk_sys);
    #1 chk(primary_position, 16'h1388, "idle position wrong");
    $display("t_swap done");
  endtask
  task automatic t_ctrl_cal;
    req(2'h2);
    wait_for(0, 2'h2);
    @(posedge clk_sys);
    #1 chk(current_op_state, 2'h0, "stuck in control calibration");
    req(2'h0);
    $display("t_ctrl_cal done");
  endtask
  task automatic t_pos_cal;
    req(2'h1);
    repeat (4) @(posedge clk_sys);
    #1 chk(current_op_state, 2'h1, "calibration not entered");
    chk(motor_drive, 16'h0000, "drive during start settle");
    wait_for(2, 2'h1);
    wait_for(1, 2'h1);
    chk({15'h0000, range_max_out > range_min_out}, 16'h0001, "learned range wrong");
    wait_for(2, 2'h1);
    req(2'h0);
    repeat (2) @(posedge clk_sys);
    #1 chk({current_op_state, motor_drive[13:0]}, 16'h0000, "abort not at once");
    $display("t_pos_cal done");
  endtask
  task automatic t_control;
    req(2'h1);
    wait_for(2, 2'h1);
    req(2'h3);
    repeat (3) @(posedge clk_sys);
    #1 chk(current_op_state, 2'h1, "pass cut short");
    wait_for(0, 2'h3);
    for (int i = 1; i < 3; i++) begin
      req(i[1:0]);
      repeat (4) @(posedge clk_sys);
      #1 chk(current_op_state, 2'h3, "left control for calibration");
    end
    req(2'h0);
    wait_for(0, 2'h0);
    $display("t_control done");
  endtask
  // ==========================================================================
  // clock and main sequence
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    {rst_n, capture_strobe, sensor_swap_select, requested_op_state} = 5'h00;
    {err_count, num_checks} = 64'h0;
    {cal_in_range_min, cal_in_range_max, pwm_switch_rate, target_position} = 64'h0000_1388_0100_1388;
    {start_settle_delay, post_up_settle_delay, post_down_settle_delay} = 48'h0002_0002_0002;
    {up_drive_initial, up_drive_step, up_drive_limit} = 48'h0320_00c8_0258;
    {down_drive_initial, down_drive_step, down_drive_limit} = 48'hfce0_ff38_fda8;
    travel_min_change = 16'sh0005;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'h1;
    @(posedge clk_sys);
    #1 chk({current_op_state, motor_drive[13:0]}, 16'h0000, "reset state");
    t_swap();
    t_ctrl_cal();
    t_pos_cal();
    t_control();
    summarize();
  end
endmodule
bind throttle_channel throttle_channel_chk #(.TICK_CYCLES(TICK_CYCLES)) chk (.clk_sys, .rst_n,
  .requested_op_state, .current_op_state, .motor_drive, .up_drive_initial, .up_drive_limit,
  .down_drive_initial, .down_drive_limit);
